// ===== inc/status_msg_regs.svh
`ifndef STATUS_MSG_REGS_SVH
`define STATUS_MSG_REGS_SVH
// Register offsets (word index on the plain register port)
`define OFF_CTRL 4'h0
`define OFF_RAISE 4'h1
`define OFF_SHOWN 4'h2
`define OFF_ERRQ 4'h3
`define OFF_COUNT 4'h4
`define OFF_COND 4'h5
// Control field positions
`define CTRL_BINARY 0
`define CTRL_SINGLE 1
`define CTRL_FAST 2
`define CTRL_EXTREF 3
// Raise register field positions
`define RAISE_CODE_LSB 0
`define RAISE_CLASS_LSB 16
// Error numbers
`define ERR_OVERFLOW 16'hfea2
`define ERR_BIN_QUERY 16'hff69
`define ERR_TIMEBASE 16'h0069
// Message codes for status messages raised by the block itself
`define MSG_ABORT_IGNORED 16'h8001
`define MSG_ACQUIRING 16'h8002
`define MSG_FAST_ARM 16'h8003
`define MSG_BINARY_OFF 16'h8004
// Timing
`define CLK_HZ 20000000
`define MOMENTARY_S 3
`define FAST_ARM_NS 131000
`define FAST_ARM_CYC ((`FAST_ARM_NS * 20) / 1000)
`endif

// ===== inc/status_msg_pkg.sv
package status_msg_pkg;
  // Message classes, one-hot, lowest to highest priority
  typedef enum logic [4:0] {
    CLS_NONE = 5'h00,
    CLS_STATIC_STATUS = 5'h01,
    CLS_MOM_STATUS = 5'h02,
    CLS_MOM_WARN = 5'h04,
    CLS_STATIC_ERR = 5'h08,
    CLS_STATIC_FAIL = 5'h10
  } msg_class_t;
endpackage

// ===== inc/errq_if.sv
`timescale 1ns/1ps
`default_nettype none
// Push and pop port of the error queue
interface errq_if;
  logic push;
  logic [15:0] push_data;
  logic pop;
  logic [15:0] pop_data;
  logic [4:0] count;
  modport owner (output push, output push_data, output pop,
    input pop_data, input count);
  modport queue (input push, input push_data, input pop,
    output pop_data, output count);
endinterface
`default_nettype wire

// ===== hdl/error_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_msg_regs.svh"
// ==========================================================
// Error queue storage
module error_fifo #(
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  errq_if.queue q
);
  localparam int AW = $clog2(DEPTH);
  logic [15:0] mem_q [DEPTH];   // Entries
  logic [AW-1:0] rd_q;          // Oldest entry
  logic [AW-1:0] wr_q;          // Next free entry
  logic [AW:0] cnt_q;           // Fill level
  logic [15:0] dout_q;          // Registered read data
  logic do_pop;
  logic do_push;
  logic full_after_pop;

  assign do_pop = q.pop && (cnt_q != '0);
  // Read precedes write, so a pop frees a slot first
  assign full_after_pop = (cnt_q == (AW+1)'(DEPTH)) && !do_pop;
  assign do_push = q.push;
  assign q.pop_data = dout_q;
  assign q.count = 5'(cnt_q);

  // Read data, zero when empty
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_q <= 16'h0000;
    end else if (q.pop) begin
      dout_q <= do_pop ? mem_q[rd_q] : 16'h0000;
    end
  end

  // Storage writes; when full the last slot takes the overflow code
  always_ff @(posedge clk) begin
    if (do_push && full_after_pop) begin
      mem_q[AW'(wr_q - 1'b1)] <= `ERR_OVERFLOW;
    end else if (do_push) begin
      mem_q[wr_q] <= q.push_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      if (do_push && !full_after_pop) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + (AW+1)'(do_push && !full_after_pop)
        - (AW+1)'(do_pop));
    end
  end
endmodule // error_fifo
`default_nettype wire

// ===== hdl/status_msg_arbiter.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "status_msg_regs.svh"
// Summary of operation
// - Five classes ranked status up to failure
// - Higher class replaces shown message at once
// - Equal class replaces only status or momentary
// - Static status stays until condition or restart
// - Momentary status clears after three seconds
// - Warning clears after three seconds, queued
// - Static error cleared by valid key, queued
// - Remote errors cleared on remote to local
// - Failure holds until restart or cleared
// - Queue holds sixteen error numbers
// - Overflow writes -350 into last slot
// - Query returns oldest error, in order
// - Empty queue query returns zero
// - Only warning, error, failure are queued
// - Graph feedback messages never queued
// - Abort in repetitive only shows status
// - Timebase change halts, raises failure 105
// - Static status during acquisition only; a software raise shows it at any time
// - Fast mode forces arming within 131 us
// - Envelope or AM in binary goes ASCII
// - Formatted query in binary gives -151
module status_msg_arbiter
  import status_msg_pkg::*;
#(
  parameter int MOM_CYCLES = `CLK_HZ * `MOMENTARY_S,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic key_valid,
  input wire logic restart,
  input wire logic remote_to_local,
  input wire logic abort_req,
  input wire logic acq_active,
  input wire logic fmt_query,
  input wire logic env_am_select,
  input wire logic extref_pin,
  input wire logic fail_cond,
  output logic meas_halt,
  output logic use_extref,
  output logic binary_mode,
  output logic [15:0] arm_limit_cycles,
  output logic [15:0] shown_code,
  output logic [4:0] shown_class
);
  // ==========================================================
  // Declarations
  errq_if eq ();
  msg_class_t cls_q;          // Shown class
  logic [15:0] code_q;        // Shown message code
  logic remote_err_q;         // Shown error came from the remote bus
  logic [31:0] tmr_q;         // Momentary timer
  logic [3:0] ctrl_q;         // Control register
  logic [31:0] rdata_q;       // Read data
  logic ext_s1_q, ext_s2_q, ext_s3_q; // External reference sync
  logic acq_s1_q, acq_s2_q, acq_s3_q; // Acquisition flag sync
  logic fail_s1_q, fail_s2_q; // Failure condition sync
  logic halt_q;               // Measurement halted
  logic extsel_q;             // Reference in use
  logic rd_err_q;             // Error queue read last cycle
  // Request of this cycle
  msg_class_t req_cls;
  logic [15:0] req_code;
  logic req_valid;
  logic req_remote;
  logic req_queued;
  logic accept;
  logic ext_change;
  logic acq_rise;
  logic acq_fall;
  logic tmr_done;
  logic sw_raise;

  assign ext_change = ext_s2_q ^ ext_s3_q;
  assign acq_rise = acq_s2_q && !acq_s3_q;
  assign acq_fall = !acq_s2_q && acq_s3_q;
  assign sw_raise = wr && (addr == `OFF_RAISE);
  assign tmr_done = (tmr_q == 32'h1);

  // ==========================================================
  // Input synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      acq_s1_q <= 1'b0;
      acq_s2_q <= 1'b0;
      acq_s3_q <= 1'b0;
      fail_s1_q <= 1'b0;
      fail_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= extref_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      acq_s1_q <= acq_active;
      acq_s2_q <= acq_s1_q;
      acq_s3_q <= acq_s2_q;
      fail_s1_q <= fail_cond;
      fail_s2_q <= fail_s1_q;
    end
  end

  // ==========================================================
  // Message source selection in fixed order: timebase, binary query, software raise, then status
  always_comb begin
    req_valid = 1'b1;
    req_remote = 1'b0;
    req_code = 16'h0000;
    req_cls = CLS_NONE;
    if (ext_change) begin
      req_cls = CLS_STATIC_FAIL;
      req_code = `ERR_TIMEBASE;
    end else if (fmt_query && ctrl_q[`CTRL_BINARY]) begin
      req_cls = CLS_STATIC_ERR;
      req_code = `ERR_BIN_QUERY;
      req_remote = 1'b1;
    end else if (sw_raise) begin
      // Software raise; class field one-hot, code in low half
      req_code = wdata[`RAISE_CODE_LSB +: 16];
      req_remote = wdata[31];
      case (wdata[`RAISE_CLASS_LSB +: 5])
        5'h01: req_cls = CLS_STATIC_STATUS;
        5'h02: req_cls = CLS_MOM_STATUS;
        5'h04: req_cls = CLS_MOM_WARN;
        5'h08: req_cls = CLS_STATIC_ERR;
        5'h10: req_cls = CLS_STATIC_FAIL;
        // Other codes, graph feedback among them, are dropped
        default: req_valid = 1'b0;
      endcase
    end else if (abort_req && !ctrl_q[`CTRL_SINGLE]) begin
      req_cls = CLS_MOM_STATUS;
      req_code = `MSG_ABORT_IGNORED;
    end else if (env_am_select && ctrl_q[`CTRL_BINARY]) begin
      req_cls = CLS_MOM_STATUS;
      req_code = `MSG_BINARY_OFF;
    end else if (wr && (addr == `OFF_CTRL) && wdata[`CTRL_FAST]
                 && !ctrl_q[`CTRL_FAST]) begin
      req_cls = CLS_MOM_STATUS;
      req_code = `MSG_FAST_ARM;
    end else if (acq_rise) begin
      req_cls = CLS_STATIC_STATUS;
      req_code = `MSG_ACQUIRING;
    end else begin
      req_valid = 1'b0;
    end
  end

  // Numbered classes go to the queue whether shown or not
  assign req_queued = req_valid && (req_cls == CLS_MOM_WARN ||
    req_cls == CLS_STATIC_ERR || req_cls == CLS_STATIC_FAIL);

  // ==========================================================
  // Replacement decision
  always_comb begin
    accept = 1'b0;
    if (req_valid) begin
      if (req_cls > cls_q) begin
        accept = 1'b1;
      end else if (req_cls == cls_q) begin
        accept = (req_cls == CLS_STATIC_STATUS) ||
          (req_cls == CLS_MOM_STATUS) ||
          (req_cls == CLS_MOM_WARN);
      end
    end
  end

  // ==========================================================
  // Shown message and its clearing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cls_q <= CLS_NONE;
      code_q <= 16'h0000;
      remote_err_q <= 1'b0;
    end else if (accept) begin
      cls_q <= req_cls;
      code_q <= req_code;
      remote_err_q <= req_remote;
    end else begin
      case (cls_q)
        CLS_STATIC_STATUS: begin
          if (restart || acq_fall) begin
            cls_q <= CLS_NONE;
          end
        end
        CLS_MOM_STATUS, CLS_MOM_WARN: begin
          if (tmr_done) begin
            cls_q <= CLS_NONE;
          end
        end
        CLS_STATIC_ERR: begin
          if (key_valid || (remote_to_local && remote_err_q)) begin
            cls_q <= CLS_NONE;
          end
        end
        CLS_STATIC_FAIL: begin
          if (restart || (!fail_s2_q && code_q != `ERR_TIMEBASE)) begin
            cls_q <= CLS_NONE;
          end
        end
        default: cls_q <= CLS_NONE;
      endcase
    end
  end

  // Three second timer for momentary messages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_q <= 32'h0;
    end else if (accept) begin
      tmr_q <= 32'(MOM_CYCLES);
    end else if (tmr_q != 32'h0) begin
      tmr_q <= tmr_q - 32'h1;
    end
  end

  // ==========================================================
  // Timebase halt and reference choice
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_q <= 1'b0;
      extsel_q <= 1'b0;
    end else if (ext_change) begin
      halt_q <= 1'b1;
    end else if (restart && halt_q) begin
      halt_q <= 1'b0;
      extsel_q <= ext_s2_q;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 4'h0;
    end else if (wr && addr == `OFF_CTRL) begin
      ctrl_q <= wdata[3:0];
    end else if (env_am_select) begin
      ctrl_q[`CTRL_BINARY] <= 1'b0;
    end
  end

  // ==========================================================
  // Error queue
  assign eq.push = req_queued;
  assign eq.push_data = req_code;
  assign eq.pop = rd && (addr == `OFF_ERRQ);

  error_fifo #(.DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .q(eq.queue)
  );

  // ==========================================================
  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0;
      rd_err_q <= 1'b0;
    end else begin
      rd_err_q <= eq.pop;
      rdata_q <= 32'h0;
      if (rd) begin
        case (addr)
          `OFF_CTRL: rdata_q <= {28'h0, ctrl_q};
          `OFF_SHOWN: rdata_q <= {11'h0, cls_q, code_q};
          `OFF_COUNT: rdata_q <= {27'h0, eq.count};
          `OFF_COND: rdata_q <= {30'h0, extsel_q, halt_q};
          default: rdata_q <= 32'h0; // Unmapped reads zero
        endcase
      end
    end
  end

  // Queue word comes from the queue's own register, sign extended
  assign rdata = rd_err_q ? {{16{eq.pop_data[15]}}, eq.pop_data}
    : rdata_q;

  // ==========================================================
  // Outputs
  assign meas_halt = halt_q;
  assign use_extref = extsel_q;
  assign binary_mode = ctrl_q[`CTRL_BINARY];
  assign arm_limit_cycles = ctrl_q[`CTRL_FAST] ?
    16'(`FAST_ARM_CYC) : 16'hffff;
  assign shown_code = code_q;
  assign shown_class = cls_q;
endmodule // status_msg_arbiter
`default_nettype wire

// ===== verification/status_msg_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Status line checker
module status_msg_checker
  import status_msg_pkg::*;
#(
  parameter int MOM_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic key_valid,
  input wire logic restart,
  input wire logic fmt_query,
  input wire logic env_am_select,
  input wire logic extref_pin,
  input wire logic fail_cond,
  input wire logic meas_halt,
  input wire logic use_extref,
  input wire logic binary_mode,
  input wire logic [15:0] arm_limit_cycles,
  input wire logic [15:0] shown_code,
  input wire logic [4:0] shown_class
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  int mcnt_q; // Cycles one momentary message has stood
  // Count how long an unchanged momentary message stays up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) mcnt_q <= 0;
    else if (shown_class inside {CLS_MOM_STATUS, CLS_MOM_WARN}
      && $stable(shown_code)) mcnt_q <= mcnt_q + 1;
    else mcnt_q <= 0;
  end
  property p_one;
    $onehot0(shown_class);
  endproperty
  a_one: assert property (p_one)
    else $error("shown class not one-hot");
  property p_idle;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside answer cycle");
  property p_fmt;
    fmt_query && binary_mode && shown_class < CLS_STATIC_ERR |->
      ##[1:2] (shown_class == CLS_STATIC_ERR && shown_code == 16'hff69);
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("binary query error not shown");
  property p_key;
    key_valid && !wr && !fmt_query && shown_class == CLS_STATIC_ERR
      |=> shown_class != CLS_STATIC_ERR;
  endproperty
  a_key: assert property (p_key)
    else $error("key did not clear error");
  property p_fail;
    shown_class == CLS_STATIC_FAIL && fail_cond && $past(fail_cond, 2)
      && !restart
      |=> shown_class == CLS_STATIC_FAIL;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failure dropped early");
  property p_ext;
    $changed(extref_pin) |-> ##[1:6] (meas_halt && shown_code == 16'h0069);
  endproperty
  a_ext: assert property (p_ext)
    else $error("timebase change not halted");
  property p_ref;
    $fell(meas_halt) |-> ##[0:2] use_extref == extref_pin;
  endproperty
  a_ref: assert property (p_ref)
    else $error("wrong timebase after restart");
  property p_env;
    env_am_select && binary_mode |-> ##[1:2] !binary_mode;
  endproperty
  a_env: assert property (p_env)
    else $error("binary output not turned off");
  property p_arm;
    wr && addr == 4'h0 |=>
      arm_limit_cycles == ($past(wdata[2]) ? 16'h0a3c : 16'hffff);
  endproperty
  a_arm: assert property (p_arm)
    else $error("arming limit does not follow fast mode");
  property p_mom;
    mcnt_q <= MOM_CYCLES;
  endproperty
  a_mom: assert property (p_mom)
    else $error("momentary message stayed too long");
endmodule // status_msg_checker
bind status_msg_arbiter status_msg_checker #(.MOM_CYCLES(MOM_CYCLES))
  status_msg_checker_inst (.clk(clk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .key_valid(key_valid), .restart(restart),
  .fmt_query(fmt_query), .env_am_select(env_am_select),
  .extref_pin(extref_pin), .fail_cond(fail_cond), .meas_halt(meas_halt),
  .use_extref(use_extref), .binary_mode(binary_mode),
  .arm_limit_cycles(arm_limit_cycles), .shown_code(shown_code),
  .shown_class(shown_class));
`default_nettype wire

// ===== verification/remote_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Remote controller on the register port
module remote_ctrl (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [3:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  // Idle bus from time zero
  initial begin
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write
  task automatic put(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the cycle after
  task automatic get(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
endmodule // remote_ctrl
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_msg_regs.svh"
// ==========
// Bench for the status line arbiter
module testbench
  import status_msg_pkg::*;
;
  localparam int MOM = 20; // Shortened momentary time
  logic clk, rst_b, acq, ext, fcond, wr, rd, halt, use_ref, bin;
  logic [5:0] ev; // Pulses: key, restart, local, abort, query, env
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] arm, code;
  logic [4:0] cls;
  int fail_count = 0;
  int n_compared = 0;
  status_msg_arbiter #(.MOM_CYCLES(MOM)) status_msg_arbiter_inst (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .key_valid(ev[0]), .restart(ev[1]),
    .remote_to_local(ev[2]), .abort_req(ev[3]), .acq_active(acq),
    .fmt_query(ev[4]), .env_am_select(ev[5]), .extref_pin(ext),
    .fail_cond(fcond), .meas_halt(halt), .use_extref(use_ref),
    .binary_mode(bin), .arm_limit_cycles(arm), .shown_code(code),
    .shown_class(cls));
  remote_ctrl remote_ctrl_inst (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task automatic raise(input logic [4:0] c, input logic [15:0] m);
    remote_ctrl_inst.put(`OFF_RAISE, {11'h0, c, m});
  endtask
  task automatic see(input int n, input logic [4:0] c, input logic [15:0] m);
    repeat (n) @(posedge clk);
    #1;
    chk({11'h0, cls, code}, {11'h0, c, m});
  endtask
  task automatic q(input logic [3:0] a, input logic [15:0] m);
    remote_ctrl_inst.get(a, d);
    chk(d, {{16{m[15]}}, m});
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    rst_b = 1'b0;
    {acq, ext, fcond} = 3'h0;
    ev = 6'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    see(1, CLS_NONE, 16'h0);
    chk(32'(arm), 32'hffff);
    q(`OFF_ERRQ, 16'h0);
    @(posedge clk) acq <= 1'b1;
    see(6, CLS_STATIC_STATUS, `MSG_ACQUIRING);
    @(posedge clk) acq <= 1'b0;
    see(6, CLS_NONE, `MSG_ACQUIRING);
    raise(CLS_STATIC_STATUS, 16'h0010);
    pulse(1);
    see(1, CLS_NONE, 16'h0010);
    $display("reset and acquisition done");
    raise(CLS_STATIC_STATUS, 16'h0011);
    see(1, CLS_STATIC_STATUS, 16'h0011);
    raise(CLS_MOM_STATUS, 16'h0012);
    raise(CLS_MOM_STATUS, 16'h0013);
    see(1, CLS_MOM_STATUS, 16'h0013);
    raise(CLS_STATIC_STATUS, 16'h0014);
    see(1, CLS_MOM_STATUS, 16'h0013);
    raise(CLS_MOM_WARN, 16'h0115);
    raise(CLS_STATIC_ERR, 16'h0116);
    raise(CLS_STATIC_ERR, 16'h0117);
    raise(5'h03, 16'h0118);
    see(1, CLS_STATIC_ERR, 16'h0116);
    q(`OFF_COUNT, 16'h3);
    pulse(0);
    see(1, CLS_NONE, 16'h0116);
    for (int i = 5; i < 8; i++) q(`OFF_ERRQ, 16'h0110 + 16'(i));
    q(`OFF_ERRQ, 16'h0);
    for (int i = 0; i < 2; i++) begin
      raise(i ? CLS_MOM_WARN : CLS_MOM_STATUS, 16'h0021);
      see(MOM - 4, i ? CLS_MOM_WARN : CLS_MOM_STATUS, 16'h0021);
      see(6, CLS_NONE, 16'h0021);
    end
    q(`OFF_ERRQ, 16'h0021);
    for (int i = 0; i < 17; i++) raise(CLS_MOM_WARN, 16'h0200 + 16'(i));
    for (int i = 0; i < 15; i++) q(`OFF_ERRQ, 16'h0200 + 16'(i));
    q(`OFF_ERRQ, `ERR_OVERFLOW);
    q(`OFF_ERRQ, 16'h0);
    $display("ranking and queue done");
    remote_ctrl_inst.put(`OFF_CTRL, 32'h1);
    raise(CLS_MOM_WARN, 16'h0031);
    fork
      q(`OFF_ERRQ, 16'h0031);
      pulse(4);
    join
    see(1, CLS_STATIC_ERR, `ERR_BIN_QUERY);
    q(`OFF_ERRQ, `ERR_BIN_QUERY);
    pulse(2);
    see(1, CLS_NONE, `ERR_BIN_QUERY);
    pulse(5);
    see(1, CLS_MOM_STATUS, `MSG_BINARY_OFF);
    chk(32'(bin), 32'h0);
    pulse(3);
    see(1, CLS_MOM_STATUS, `MSG_ABORT_IGNORED);
    remote_ctrl_inst.put(`OFF_CTRL, 32'h4);
    see(2, CLS_MOM_STATUS, `MSG_FAST_ARM);
    chk(32'(arm), 32'h0a3c);
    q(`OFF_COUNT, 16'h0);
    remote_ctrl_inst.get(`OFF_SHOWN, d);
    chk(d, {11'h0, CLS_MOM_STATUS, `MSG_FAST_ARM});
    remote_ctrl_inst.get(`OFF_CTRL, d);
    chk(d, 32'h4);
    remote_ctrl_inst.put(`OFF_CTRL, 32'h6);
    pulse(3);
    see(1, CLS_MOM_STATUS, `MSG_FAST_ARM);
    raise(CLS_STATIC_ERR, 16'h0040);
    pulse(2);
    see(1, CLS_STATIC_ERR, 16'h0040);
    pulse(0);
    remote_ctrl_inst.put(`OFF_RAISE,
      {1'b1, 10'h0, CLS_STATIC_ERR, 16'h0041});
    pulse(2);
    see(1, CLS_NONE, 16'h0041);
    $display("binary and modes done");
    @(posedge clk) fcond <= 1'b1;
    raise(CLS_STATIC_FAIL, 16'h006c);
    see(3, CLS_STATIC_FAIL, 16'h006c);
    pulse(1);
    see(1, CLS_NONE, 16'h006c);
    raise(CLS_STATIC_FAIL, 16'h006d);
    @(posedge clk) fcond <= 1'b0;
    see(3, CLS_NONE, 16'h006d);
    @(posedge clk) ext <= 1'b1;
    see(8, CLS_STATIC_FAIL, `ERR_TIMEBASE);
    chk(32'(halt), 32'h1);
    pulse(1);
    see(2, CLS_NONE, `ERR_TIMEBASE);
    chk({30'h0, halt, use_ref}, 32'h1);
    remote_ctrl_inst.get(`OFF_COND, d);
    chk(d, 32'h2);
    q(`OFF_ERRQ, 16'h0040);
    q(`OFF_ERRQ, 16'h0041);
    q(`OFF_ERRQ, 16'h006c);
    q(`OFF_ERRQ, 16'h006d);
    q(`OFF_ERRQ, `ERR_TIMEBASE);
    $display("failure and timebase done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
